// file: rtl/scp_pkg.sv
package scp_pkg;
  // bus and datapath widths
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 8;
  localparam int PHASE_W = 6;
  localparam int PHASES  = 64;
  localparam int ADC_W   = 14;

  // register offsets
  localparam logic [7:0] OFS_MAIN_CFG     = 8'h00;
  localparam logic [7:0] OFS_SH_CTRL      = 8'h06;
  localparam logic [7:0] OFS_CLK_MON      = 8'h09;
  localparam logic [7:0] OFS_CLAMP_START  = 8'h20;
  localparam logic [7:0] OFS_CLAMP_END    = 8'h21;
  localparam logic [7:0] OFS_SAMPLE_START = 8'h22;
  localparam logic [7:0] OFS_SAMPLE_END   = 8'h23;

  // field positions and codes
  localparam int         MAIN_CDS_BIT   = 0;
  localparam int         SH_ENABLE_BIT  = 7;
  localparam int         MON_SEL_HI     = 4;
  localparam int         MON_SEL_LO     = 3;
  localparam logic [1:0] MON_SEL_PULSES = 2'h2;

  // reset values (baseline leaves sample-and-hold on)
  localparam logic [7:0] MAIN_CFG_RESET     = 8'h00;
  localparam logic [7:0] SH_CTRL_RESET      = 8'h80;
  localparam logic [7:0] CLK_MON_RESET      = 8'h00;
  localparam logic [7:0] CLAMP_START_RESET  = 8'h08;
  localparam logic [7:0] CLAMP_END_RESET    = 8'h10;
  localparam logic [7:0] SAMPLE_START_RESET = 8'h20;
  localparam logic [7:0] SAMPLE_END_RESET   = 8'h30;
  localparam logic [7:0] READ_UNMAPPED      = 8'h00;

  // phase and frame marker timing
  localparam logic [PHASE_W-1:0] PHASE_ZERO = 6'h00;
  localparam logic [PHASE_W-1:0] PHASE_LAST = 6'h3F;
  localparam int         BITCLK_CYCLES  = 8;
  localparam logic [1:0] MARK_BITS_ODD  = 2'h3;
  localparam logic [1:0] MARK_BITS_EVEN = 2'h2;
  localparam logic [1:0] MARK_BITS_SH   = 2'h3;
  localparam logic [1:0] MARK_BITS_NONE = 2'h0;
endpackage : scp_pkg

// file: rtl/scp_frame_marker.sv
module scp_frame_marker #(
  parameter int BIT_CYCLES = scp_pkg::BITCLK_CYCLES  // clk cycles per output bit clock
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // pixel timing from the sampling stage
  input  wire logic pixelStart,
  input  wire logic markOdd,
  input  wire logic cdsMode,
  // serial frame pins
  output logic      outputBitClock,
  output logic      pixelFrameMarker
);
  import scp_pkg::*;

  localparam int               CNT_W    = $clog2(BIT_CYCLES);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(BIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_HALF = CNT_W'(BIT_CYCLES / 2);

  // whole state of the marker generator
  typedef struct packed {
    logic [CNT_W-1:0] divCnt;    // position inside one bit clock
    logic [1:0]       bitsLeft;  // bit periods the marker still stays high
    logic             bitClk;    // registered bit clock
    logic             marker;    // registered frame marker
  } scp_mark_state_t;

  localparam scp_mark_state_t MARK_RESET = '{divCnt: '0, bitsLeft: MARK_BITS_NONE,
                                             bitClk: 1'b1, marker: 1'b0};

  scp_mark_state_t st_reg;   // current state
  scp_mark_state_t st_next;  // next state

  // next state: divider and marker length
  always_comb
  begin
    st_next = st_reg;
    if (pixelStart)
    begin
      // width tells the path of the pixel
      st_next.divCnt = '0;
      if (!cdsMode)
        st_next.bitsLeft = MARK_BITS_SH;  // [RQ16]
      else if (markOdd)
        st_next.bitsLeft = MARK_BITS_ODD;  // [RQ14]
      else
        st_next.bitsLeft = MARK_BITS_EVEN;  // [RQ15]
    end
    else if (st_reg.divCnt == CNT_LAST)
    begin
      // end of one bit period
      st_next.divCnt = '0;
      if (st_reg.bitsLeft != MARK_BITS_NONE)
        st_next.bitsLeft = st_reg.bitsLeft - 2'h1;
    end
    else
      st_next.divCnt = st_reg.divCnt + 1'b1;
    st_next.bitClk = st_next.divCnt < CNT_HALF;
    st_next.marker = st_next.bitsLeft != MARK_BITS_NONE;
  end

  // state register, synchronous reset
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      st_reg <= MARK_RESET;
    else
      st_reg <= st_next;
  end

  assign outputBitClock   = st_reg.bitClk;
  assign pixelFrameMarker = st_reg.marker;

  // marker widths per pixel kind
  a_marker_odd_width: assert property (@(posedge clk) disable iff (!rst_n)  // [RQ14]
    (pixelStart && cdsMode && markOdd) |=> pixelFrameMarker ##23 pixelFrameMarker ##1 !pixelFrameMarker)
    else $error("odd pixel marker not three bit periods");
  a_marker_even_width: assert property (@(posedge clk) disable iff (!rst_n)  // [RQ15]
    (pixelStart && cdsMode && !markOdd) |=> pixelFrameMarker ##15 pixelFrameMarker ##1 !pixelFrameMarker)
    else $error("even pixel marker not two bit periods");
  a_marker_sh_width: assert property (@(posedge clk) disable iff (!rst_n)  // [RQ16]
    (pixelStart && !cdsMode) |=> pixelFrameMarker ##23 pixelFrameMarker ##1 !pixelFrameMarker)
    else $error("sample-and-hold marker not three bit periods");
  c_even_marker: cover property (@(posedge clk) disable iff (!rst_n) pixelStart && cdsMode && !markOdd);
endmodule // scp_frame_marker

// file: rtl/scp_sample_timing.sv
// Notes on behaviour
// [RQ1] bit 0 of main config selects CDS
// [RQ2] S/H bit 7 must be off first
// [RQ3] reset values leave S/H mode active
// [RQ4] 64 phase edges per input clock period
// [RQ5] sample pulse from start to end edge
// [RQ6] clamp edges ignored in S/H mode
// [RQ7] start above end wraps into next period
// [RQ8] monitor code 10 routes pulses to pins
// [RQ9] CDS monitor shows odd clamp and sample
// [RQ10] CDS alternates even and odd networks
// [RQ11] both paths share one edge register set
// [RQ12] CDS result is reference minus video
// [RQ13] early sample edges delay to next period
// [RQ14] odd pixel marker high three bit clocks
// [RQ15] even pixel marker high two bit clocks
// [RQ16] S/H marker always three bit clocks
// [RQ17] host should widen pulses toward far edge
// [RQ18] pulse covers start through end inclusive
// [RQ19] path toggles once per clock period
module scp_sample_timing #(
  parameter int BIT_CYCLES = scp_pkg::BITCLK_CYCLES  // clk cycles per output bit clock
) (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // decoded configuration access
  input  wire logic                        regWe,
  input  wire logic [scp_pkg::ADDR_W-1:0]  regAddr,
  input  wire logic [scp_pkg::DATA_W-1:0]  regWdata,
  output logic      [scp_pkg::DATA_W-1:0]  regRdata,
  // sensor levels, digitised
  input  wire logic [scp_pkg::ADC_W-1:0]   positiveSensorInput,
  input  wire logic [scp_pkg::ADC_W-1:0]   negativeSensorInput,
  // sampling network pulses
  output logic                             evenClampPulse,
  output logic                             evenSamplePulse,
  output logic                             oddPathClampPulse,
  output logic                             oddPathSamplingPulse,
  // mode and path status
  output logic                             cdsActive,
  output logic                             pathOdd,
  // monitor pins
  output logic                             monitorPinFirst,
  output logic                             monitorPinSecond,
  // pixel result
  output logic      [scp_pkg::ADC_W-1:0]   pixelResult,
  output logic                             resultValid,
  // serial frame pins
  output logic                             outputBitClock,
  output logic                             pixelFrameMarker
);
  import scp_pkg::*;

  // whole state of the timing block
  typedef struct packed {
    logic [DATA_W-1:0]  mainCfg;      // main configuration
    logic [DATA_W-1:0]  shCtrl;       // sample-and-hold control
    logic [DATA_W-1:0]  clkMon;       // clock monitor select
    logic [DATA_W-1:0]  clampStart;   // clamp start edge
    logic [DATA_W-1:0]  clampEnd;     // clamp end edge
    logic [DATA_W-1:0]  sampleStart;  // sample start edge
    logic [DATA_W-1:0]  sampleEnd;    // sample end edge
    logic [DATA_W-1:0]  rdata;        // read data
    logic [PHASE_W-1:0] phase;        // current phase edge
    logic               pathOdd;      // path of this period
    logic               clampOn;      // clamp pulse high
    logic               odd_path_clamp_pulse;     // clamp belongs to odd path
    logic               sampleOn;     // sample pulse high
    logic               odd_path_sampling_pulse;    // sample belongs to odd path
    logic [ADC_W-1:0]   refLevel;     // captured reference level
    logic [ADC_W-1:0]   result;       // last pixel result
    logic               resValid;     // result strobe
  } scp_time_state_t;

  localparam scp_time_state_t TIME_RESET = '{
    mainCfg:     MAIN_CFG_RESET,
    shCtrl:      SH_CTRL_RESET,  // [RQ3]
    clkMon:      CLK_MON_RESET,
    clampStart:  CLAMP_START_RESET,
    clampEnd:    CLAMP_END_RESET,
    sampleStart: SAMPLE_START_RESET,
    sampleEnd:   SAMPLE_END_RESET,
    rdata:       READ_UNMAPPED,
    phase:       PHASE_ZERO,
    pathOdd:     1'b0,
    clampOn:     1'b0,
    odd_path_clamp_pulse:    1'b0,
    sampleOn:    1'b0,
    odd_path_sampling_pulse:   1'b0,
    refLevel:    '0,
    result:      '0,
    resValid:    1'b0
  };

  scp_time_state_t    st_reg;        // current state
  scp_time_state_t    st_next;       // next state

  logic               cdsMode;       // CDS selected and S/H off
  logic               monSel;        // monitor shows pulses
  logic [PHASE_W-1:0] nextPhase;     // phase of next cycle
  logic [PHASE_W-1:0] clampStart6;   // clamp start index
  logic [PHASE_W-1:0] clampEnd6;     // clamp end index
  logic [PHASE_W-1:0] sampleStart6;  // sample start index
  logic [PHASE_W-1:0] sampleEnd6;    // sample end index
  logic               pathNext;      // path of next cycle
  logic               sampleLate;    // sample after clamp period
  logic               cStartHit;     // clamp begins next cycle
  logic               cEndHit;       // clamp ends this cycle
  logic               sStartHit;     // sample begins next cycle
  logic               sEndHit;       // sample ends this cycle
  logic               pixelStart;    // last phase of a period

  // mode decode: CDS only while S/H is off
  assign cdsMode = st_reg.mainCfg[MAIN_CDS_BIT] & ~st_reg.shCtrl[SH_ENABLE_BIT];  // [RQ1] [RQ2]
  assign monSel  = st_reg.clkMon[MON_SEL_HI:MON_SEL_LO] == MON_SEL_PULSES;

  // edge indices, one shared set for both paths
  assign clampStart6  = st_reg.clampStart[PHASE_W-1:0];  // [RQ11]
  assign clampEnd6    = st_reg.clampEnd[PHASE_W-1:0];
  assign sampleStart6 = st_reg.sampleStart[PHASE_W-1:0];
  assign sampleEnd6   = st_reg.sampleEnd[PHASE_W-1:0];

  // phase counter wraps at 64 edges
  assign nextPhase  = st_reg.phase + 6'h01;  // [RQ4]
  assign pixelStart = st_reg.phase == PHASE_LAST;

  // path flips at each period start, held even in S/H
  assign pathNext = cdsMode & (st_reg.pathOdd ^ (nextPhase == PHASE_ZERO));  // [RQ10] [RQ19]

  // sample edges below clamp edges: sample in next period
  assign sampleLate = cdsMode & (sampleStart6 < clampStart6) & (sampleEnd6 < clampEnd6);  // [RQ13]

  // pulse boundary detection, modulo 64 by construction
  assign cStartHit = cdsMode & (nextPhase == clampStart6);  // [RQ6]
  assign cEndHit   = st_reg.clampOn & (st_reg.phase == clampEnd6);  // [RQ18]
  assign sStartHit = nextPhase == sampleStart6;  // [RQ5]
  assign sEndHit   = st_reg.sampleOn & (st_reg.phase == sampleEnd6);  // [RQ5] [RQ7]

  // next state
  always_comb
  begin
    st_next          = st_reg;
    st_next.phase    = nextPhase;
    st_next.pathOdd  = pathNext;
    st_next.resValid = 1'b0;

    // clamp pulse, dropped at once when leaving CDS
    st_next.clampOn = cdsMode & (cStartHit | (st_reg.clampOn & ~cEndHit));  // [RQ6] [RQ18]
    if (cStartHit)
      st_next.odd_path_clamp_pulse = pathNext;  // [RQ10]

    // sample pulse, held across the period edge when wrapping
    st_next.sampleOn = sStartHit | (st_reg.sampleOn & ~sEndHit);  // [RQ7] [RQ18]
    if (sStartHit)
    begin
      // late sample pairs with previous period's clamp
      if (sampleLate)
        st_next.odd_path_sampling_pulse = ~pathNext;  // [RQ13]
      else
        st_next.odd_path_sampling_pulse = pathNext;  // [RQ10]
    end

    // reference captured as clamp closes
    if (cdsMode && cEndHit)
      st_next.refLevel = negativeSensorInput;  // [RQ12]

    // video captured as sample closes
    if (sEndHit)
    begin
      st_next.resValid = 1'b1;
      if (cdsMode)
        st_next.result = ADC_W'(st_reg.refLevel - negativeSensorInput);  // [RQ12]
      else
        st_next.result = ADC_W'(positiveSensorInput - negativeSensorInput);
    end

    // register read, one cycle latency
    case (regAddr)
      OFS_MAIN_CFG:     st_next.rdata = st_reg.mainCfg;
      OFS_SH_CTRL:      st_next.rdata = st_reg.shCtrl;
      OFS_CLK_MON:      st_next.rdata = st_reg.clkMon;
      OFS_CLAMP_START:  st_next.rdata = st_reg.clampStart;
      OFS_CLAMP_END:    st_next.rdata = st_reg.clampEnd;
      OFS_SAMPLE_START: st_next.rdata = st_reg.sampleStart;
      OFS_SAMPLE_END:   st_next.rdata = st_reg.sampleEnd;
      default:          st_next.rdata = READ_UNMAPPED;
    endcase

    // register write, unmapped addresses ignored
    if (regWe)
    begin
      case (regAddr)
        OFS_MAIN_CFG:     st_next.mainCfg     = regWdata;  // [RQ1]
        OFS_SH_CTRL:      st_next.shCtrl      = regWdata;  // [RQ2]
        OFS_CLK_MON:      st_next.clkMon      = regWdata;  // [RQ8]
        OFS_CLAMP_START:  st_next.clampStart  = regWdata;
        OFS_CLAMP_END:    st_next.clampEnd    = regWdata;
        OFS_SAMPLE_START: st_next.sampleStart = regWdata;
        OFS_SAMPLE_END:   st_next.sampleEnd   = regWdata;
        default:          st_next.rdata       = st_next.rdata;
      endcase
    end
  end

  // state register, synchronous reset
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      st_reg <= TIME_RESET;
    else
      st_reg <= st_next;
  end

  // per-path pulses from shared pulse flops
  assign evenClampPulse       = st_reg.clampOn & ~st_reg.odd_path_clamp_pulse;  // [RQ11]
  assign oddPathClampPulse    = st_reg.clampOn & st_reg.odd_path_clamp_pulse;
  assign evenSamplePulse      = st_reg.sampleOn & ~st_reg.odd_path_sampling_pulse;
  assign oddPathSamplingPulse = st_reg.sampleOn & st_reg.odd_path_sampling_pulse;

  // monitor routing: odd path only in CDS
  always_comb
  begin
    monitorPinFirst  = 1'b0;
    monitorPinSecond = 1'b0;
    if (monSel && cdsMode)
    begin
      monitorPinFirst  = oddPathClampPulse;  // [RQ9]
      monitorPinSecond = oddPathSamplingPulse;  // [RQ9]
    end
    else if (monSel)
    begin
      monitorPinFirst  = st_reg.clampOn;  // [RQ8]
      monitorPinSecond = st_reg.sampleOn;  // [RQ8]
    end
  end

  // status and data outputs
  assign regRdata    = st_reg.rdata;
  assign cdsActive   = cdsMode;
  assign pathOdd     = st_reg.pathOdd;
  assign pixelResult = st_reg.result;
  assign resultValid = st_reg.resValid;

  // frame marker and bit clock
  scp_frame_marker #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_marker (
    .clk              (clk),
    .rst_n            (rst_n),
    .pixelStart       (pixelStart),
    .markOdd          (pathNext),  // [RQ14] [RQ15]
    .cdsMode          (cdsMode),
    .outputBitClock   (outputBitClock),
    .pixelFrameMarker (pixelFrameMarker)
  );

  // checks on timing and routing
  a_phase_wrap: assert property (@(posedge clk) disable iff (!rst_n)  // [RQ4]
    (st_reg.phase == PHASE_LAST) |=> (st_reg.phase == PHASE_ZERO) ##63 (st_reg.phase == PHASE_LAST))
    else $error("phase counter not 64 edges");
  a_clamp_sh_quiet: assert property (@(posedge clk) disable iff (!rst_n)  // [RQ6]
    !cdsMode |=> !st_reg.clampOn)
    else $error("clamp pulse active in sample-and-hold");
  a_path_toggle: assert property (@(posedge clk) disable iff (!rst_n)  // [RQ19]
    (cdsMode && pixelStart) |=> (st_reg.pathOdd != $past(st_reg.pathOdd)))
    else $error("path did not toggle at period start");
  a_path_steady: assert property (@(posedge clk) disable iff (!rst_n)  // [RQ10]
    (cdsMode && !pixelStart) |=> $stable(st_reg.pathOdd))
    else $error("path changed inside a period");
  a_sample_start: assert property (@(posedge clk) disable iff (!rst_n)  // [RQ5]
    sStartHit |=> st_reg.sampleOn && (st_reg.phase == $past(sampleStart6)))
    else $error("sample pulse not started at start edge");
  a_sample_end: assert property (@(posedge clk) disable iff (!rst_n)  // [RQ18]
    (sEndHit && !sStartHit) |=> !st_reg.sampleOn)
    else $error("sample pulse not ended after end edge");
  a_late_owner: assert property (@(posedge clk) disable iff (!rst_n)  // [RQ13]
    (sStartHit && sampleLate) |=> (st_reg.odd_path_sampling_pulse != st_reg.pathOdd))
    else $error("late sample not paired with previous period");
  a_monitor_route: assert property (@(posedge clk) disable iff (!rst_n)  // [RQ9]
    (monSel && cdsMode) |-> (monitorPinFirst == oddPathClampPulse)
                            && (monitorPinSecond == oddPathSamplingPulse))
    else $error("monitor pins not showing odd path");
  a_result_cds: assert property (@(posedge clk) disable iff (!rst_n)  // [RQ12]
    (cdsMode && sEndHit) |=> resultValid
      && (pixelResult == ADC_W'($past(st_reg.refLevel) - $past(negativeSensorInput))))
    else $error("CDS result not reference minus video");

  // clamp begins on its start edge
  a_clamp_start: assert property (@(posedge clk) disable iff (!rst_n)  // [RQ18]
    cStartHit |=> st_reg.clampOn && (st_reg.phase == $past(clampStart6)))
    else $error("clamp not started at start edge");

  // clamp drops after its end edge
  a_clamp_end: assert property (@(posedge clk) disable iff (!rst_n)  // [RQ18]
    (cEndHit && !cStartHit) |=> !st_reg.clampOn)
    else $error("clamp not ended after end edge");

  // clamp owned by the period it starts in
  a_clamp_owner: assert property (@(posedge clk) disable iff (!rst_n)  // [RQ10]
    cStartHit |=> (st_reg.odd_path_clamp_pulse == st_reg.pathOdd))
    else $error("clamp on wrong path");

  // in-period sample owned by that period
  a_sample_owner: assert property (@(posedge clk) disable iff (!rst_n)  // [RQ10]
    (sStartHit && !sampleLate) |=> (st_reg.odd_path_sampling_pulse == st_reg.pathOdd))
    else $error("sample on wrong path");

  // single path in sample-and-hold
  a_sh_one_path: assert property (@(posedge clk) disable iff (!rst_n)  // [RQ16]
    !cdsMode |=> !st_reg.pathOdd)
    else $error("odd path used in sample-and-hold");

  // s/h enable blocks cds
  a_sh_blocks_cds: assert property (@(posedge clk) disable iff (!rst_n)  // [RQ2]
    st_reg.shCtrl[SH_ENABLE_BIT] |-> !cdsActive)
    else $error("cds active with s/h on");

  // reset leaves s/h mode
  a_baseline_sh: assert property (@(posedge clk) disable iff (!rst_n)  // [RQ3]
    $rose(rst_n) |-> !cdsActive)
    else $error("cds active after reset");

  // monitor pins quiet unless selected
  a_monitor_off: assert property (@(posedge clk) disable iff (!rst_n)  // [RQ8]
    !monSel |-> !monitorPinFirst && !monitorPinSecond)
    else $error("monitor pins driven unselected");

  // marker rises with the period
  a_marker_phase: assert property (@(posedge clk) disable iff (!rst_n)  // [RQ14]
    $rose(pixelFrameMarker) |-> (st_reg.phase == PHASE_ZERO))
    else $error("marker not at period start");

  // result strobe follows a closed sample
  a_result_strobe: assert property (@(posedge clk) disable iff (!rst_n)  // [RQ12]
    resultValid |-> $past(sEndHit))
    else $error("result strobe without sample");

  // wrapping sample held across period edge
  a_sample_wrap: assert property (@(posedge clk) disable iff (!rst_n)  // [RQ7]
    (st_reg.sampleOn && pixelStart && (sampleStart6 > sampleEnd6)) |=> st_reg.sampleOn)
    else $error("wrapping sample cut at period edge");

  c_cds_odd_sample: cover property (@(posedge clk) disable iff (!rst_n) cdsMode && oddPathSamplingPulse);
  c_wrap_sample: cover property (@(posedge clk) disable iff (!rst_n)
    st_reg.sampleOn && (st_reg.phase == PHASE_ZERO) && (sampleStart6 > sampleEnd6));
  c_late_sample: cover property (@(posedge clk) disable iff (!rst_n) sStartHit && sampleLate);
  c_mon_sample: cover property (@(posedge clk) disable iff (!rst_n) monSel && monitorPinSecond);
endmodule // scp_sample_timing

// file: tb/scp_sensor_model.sv
// behavioural sensor output: reference and video portions follow the pulses
module scp_sensor_model
  import scp_pkg::*;
#(
  parameter logic [13:0] REF_LEVEL = 14'h2A00,  // reference portion level
  parameter logic [13:0] VID_LEVEL = 14'h0C35   // video portion level
) (
  // clock
  input  wire logic                     clk,
  // pulses seen from the front end
  input  wire logic                     clampPulse,
  input  wire logic                     samplePulse,
  input  wire logic                     cdsMode,
  // sensor levels
  output logic      [scp_pkg::ADC_W-1:0] positiveSensorInput,
  output logic      [scp_pkg::ADC_W-1:0] negativeSensorInput
);
  // levels change only off the sampling edge
  initial
  begin
    positiveSensorInput = REF_LEVEL;
    negativeSensorInput = 14'h0000;
  end

  // one pixel waveform: reference, then video, junk in between
  always @(negedge clk)
  begin
    if (clampPulse)
      negativeSensorInput <= REF_LEVEL;  // reference on the negative input
    else if (samplePulse)
      negativeSensorInput <= VID_LEVEL;  // video on the negative input
    else
      negativeSensorInput <= ~negativeSensorInput;  // unsettled between portions
    positiveSensorInput <= cdsMode ? 14'h0000 : REF_LEVEL;  // bypassed in cds, reference in s/h
  end
endmodule // scp_sensor_model

// file: tb/sample_clamp_pulse_timing_test.sv
module sample_clamp_pulse_timing_test;
  timeunit 1ns;
  timeprecision 1ps;
  import scp_pkg::*;

  localparam logic [13:0] REF_LEVEL = 14'h2A00;  // model reference
  localparam logic [13:0] VID_LEVEL = 14'h0C35;  // model video

  // clock, reset, register port
  logic                clk;
  logic                rst_n;
  logic                regWe;
  logic [ADDR_W-1:0]   regAddr;
  logic [DATA_W-1:0]   regWdata;
  logic [DATA_W-1:0]   regRdata;
  // sensor and pulses
  logic [ADC_W-1:0]    posIn;
  logic [ADC_W-1:0]    negIn;
  logic                evC, evS, odC, odS;
  logic                cdsActive, pathOdd, monA, monB;
  logic [ADC_W-1:0]    pixelResult;
  logic                resultValid, pixelFrameMarker;
  // observation vector {bitClk,evC,evS,odC,odS,monA,monB,mark}
  logic                bitClk;
  logic [7:0]          obs;
  int                  cnt [8];
  int                  first [8];
  logic                odd0;
  logic                lastOdd;
  int                  nErrors;
  int                  nChecks;

  assign obs = {bitClk, evC, evS, odC, odS, monA, monB, pixelFrameMarker};

  scp_sample_timing DUT (
    .clk(clk), .rst_n(rst_n), .regWe(regWe), .regAddr(regAddr), .regWdata(regWdata),
    .regRdata(regRdata), .positiveSensorInput(posIn), .negativeSensorInput(negIn),
    .evenClampPulse(evC), .evenSamplePulse(evS), .oddPathClampPulse(odC),
    .oddPathSamplingPulse(odS), .cdsActive(cdsActive), .pathOdd(pathOdd),
    .monitorPinFirst(monA), .monitorPinSecond(monB), .pixelResult(pixelResult),
    .resultValid(resultValid), .outputBitClock(bitClk), .pixelFrameMarker(pixelFrameMarker)
  );

  scp_sensor_model #(.REF_LEVEL(REF_LEVEL), .VID_LEVEL(VID_LEVEL)) sensor (
    .clk(clk), .clampPulse(evC | odC), .samplePulse(evS | odS), .cdsMode(cdsActive),
    .positiveSensorInput(posIn), .negativeSensorInput(negIn)
  );

  // free running clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // verdict and end of run
  task automatic conclude();
    if (nErrors == 0 && nChecks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // one comparison
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    nChecks++;
    if (got !== exp)
    begin
      nErrors++;
      $display("MISMATCH %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  // register write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regWe = 1'b1;
    regAddr = a;
    regWdata = d;
    @(negedge clk);
    regWe = 1'b0;
  endtask

  // register read, data one edge later
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    regAddr = a;
    @(negedge clk);
    chk({8'h00, regRdata}, {8'h00, exp}, "register read");
  endtask

  // sync to phase 0 by marker rise, then profile one 64-edge period
  task automatic period();
    int i;
    int b;
    logic prev;
    prev = pixelFrameMarker;  // back-to-back calls must not skip a period
    for (i = 0; i < 200; i++)
    begin
      @(negedge clk);
      if (pixelFrameMarker === 1'b1 && prev === 1'b0)
        break;
      prev = pixelFrameMarker;
    end
    if (i == 200)
    begin
      nErrors++;
      conclude();
    end
    odd0 = pathOdd;
    for (b = 0; b < 8; b++)
    begin
      cnt[b] = 0;
      first[b] = -1;
    end
    for (i = 0; i < 64; i++)
    begin
      if (i > 0)
        @(negedge clk);
      for (b = 0; b < 8; b++)
        if (obs[b] === 1'b1)
        begin
          cnt[b]++;
          if (first[b] < 0)
            first[b] = i;
        end
    end
  endtask

  // bounded wait for a fresh result
  task automatic result();
    int i;
    for (i = 0; i < 100; i++)
    begin
      @(negedge clk);
      if (resultValid === 1'b1)
        break;
    end
    if (i == 100)
    begin
      nErrors++;
      conclude();
    end
    chk({2'b00, pixelResult}, {2'b00, REF_LEVEL - VID_LEVEL}, "pixel result");
  endtask

  // main sequence
  initial
  begin
    int k;
    nErrors = 0;
    nChecks = 0;
    rst_n = 1'b0;
    regWe = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    // reset values and an unmapped read
    rd(OFS_MAIN_CFG, MAIN_CFG_RESET);
    rd(OFS_SH_CTRL, SH_CTRL_RESET);
    rd(OFS_CLK_MON, CLK_MON_RESET);
    rd(OFS_CLAMP_START, CLAMP_START_RESET);
    rd(OFS_CLAMP_END, CLAMP_END_RESET);
    rd(OFS_SAMPLE_START, SAMPLE_START_RESET);
    rd(OFS_SAMPLE_END, SAMPLE_END_RESET);
    rd(8'h01, READ_UNMAPPED);
    chk({15'h0, cdsActive}, 16'h0000, "baseline mode");
    // s/h: sample 5..10, clamp ignored, monitor off
    wr(OFS_SAMPLE_START, 8'h05);
    wr(OFS_SAMPLE_END, 8'h0A);
    rd(OFS_SAMPLE_END, 8'h0A);
    period();
    chk(first[5], 5, "sample start edge");
    chk(cnt[5], 6, "sample width");
    chk(cnt[6] + cnt[4], 0, "clamp in s/h");
    chk(cnt[0], 24, "s/h marker");
    chk(cnt[1], 0, "monitor idle");
    chk(first[7], 0, "bit clock restart");
    chk(cnt[7], 32, "bit clock high edges");
    result();
    // monitor code 10 routes the pulses
    wr(OFS_CLK_MON, 8'h10);
    period();
    chk(first[1], 5, "monitor sample start");
    chk(cnt[1], 6, "monitor sample width");
    // wrapping pulse, 60 through 3
    wr(OFS_SAMPLE_START, 8'h3C);
    wr(OFS_SAMPLE_END, 8'h03);
    period();
    period();
    chk(first[5], 0, "wrap first edge");
    chk(cnt[5], 8, "wrap width");
    // full period covers all 64 edges
    wr(OFS_SAMPLE_START, 8'h00);
    wr(OFS_SAMPLE_END, 8'h3F);
    period();
    period();
    chk(cnt[5], 64, "edges per period");
    // cds: clamp 8..16, sample 32..48 near far portion edges
    wr(OFS_SAMPLE_START, 8'h20);
    wr(OFS_SAMPLE_END, 8'h30);
    wr(OFS_SH_CTRL, 8'h00);
    wr(OFS_MAIN_CFG, 8'h01);
    chk({15'h0, cdsActive}, 16'h0001, "cds selected");
    period();
    lastOdd = odd0;
    for (k = 0; k < 4; k++)
    begin
      period();
      chk({15'h0, odd0}, {15'h0, ~lastOdd}, "path toggle");
      lastOdd = odd0;
      chk(first[odd0 ? 4 : 6], 8, "clamp start");
      chk(cnt[odd0 ? 4 : 6], 9, "clamp width");
      chk(first[odd0 ? 3 : 5], 32, "sample start");
      chk(cnt[odd0 ? 3 : 5], 17, "sample width");
      chk(cnt[odd0 ? 6 : 4] + cnt[odd0 ? 5 : 3], 0, "other path idle");
      chk(cnt[2], odd0 ? 9 : 0, "monitor odd clamp");
      chk(cnt[1], odd0 ? 17 : 0, "monitor odd sample");
      chk(cnt[0], odd0 ? 24 : 16, "cds marker");
    end
    result();
    // sample edges below clamp edges go to the next period
    wr(OFS_SAMPLE_START, 8'h02);
    wr(OFS_SAMPLE_END, 8'h04);
    period();
    for (k = 0; k < 2; k++)
    begin
      period();
      chk(first[odd0 ? 5 : 3], 2, "delayed sample start");
      chk(cnt[odd0 ? 5 : 3], 3, "delayed sample width");
      chk(cnt[odd0 ? 3 : 5], 0, "own path sample");
    end
    conclude();
  end
endmodule // sample_clamp_pulse_timing_test
